// ---- rtl/adc_serial_pkg.sv ----
// constants and types shared by both ends of the converter serial link
// Function
// - device listens only while select is low
// - shift on clock fall, sample on rise
// - receive configuration first, then transmit result
// - shared data line; host releases while device sends
// - select fall starts exchange; hunt start bit
// - start bit, 3 or 6 configuration bits
// - one null bit, then the result
// - select high ends exchange, resets sequencer
// - no-input variant: first clock enables output
// - no-input variant: fixed differential unipolar
// - no-input variant: msb first then lsb first
// - first sampled one is start; zeros ignored
// - input ignored after word until reselect
// - configuration bits set the multiplexer
// - single-ended against ground or shared return
// - two-channel mode and parity select pair
// - bit order one: msb first, zero fill
// - bit order zero: msb then lsb first
// - polarity one unipolar; two-channel always unipolar
`default_nettype none
package adc_serial_pkg;
	typedef enum logic [1:0] {
		VAR_TWO_CH   = 2'h0,
		VAR_NO_DIN   = 2'h1,
		VAR_SIX_CH   = 2'h2,
		VAR_EIGHT_CH = 2'h3
	} variant_t;
	typedef enum logic [2:0] {
		DS_IDLE  = 3'h0,
		DS_HUNT  = 3'h1,
		DS_CFG   = 3'h2,
		DS_ARMED = 3'h3,
		DS_TX    = 3'h4
	} dev_state_t;
	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_SETUP = 2'h1,
		HS_CLK   = 2'h2,
		HS_GAP   = 2'h3
	} host_state_t;
	localparam int         RESULT_W       = 10;
	localparam logic [2:0] CFG_BITS_TWO   = 3'h3;
	localparam logic [2:0] CFG_BITS_MULTI = 3'h6;
	// word field positions, first received bit at the top
	localparam int         POS_MODE       = 5;
	localparam int         POS_PARITY     = 4;
	localparam int         POS_SEL_HI     = 3;
	localparam int         POS_SEL_LO     = 2;
	localparam int         POS_POLARITY   = 1;
	localparam int         POS_ORDER      = 0;
	// output bit index: 0 null, 1..10 msb first, 11..19 lsb first, then fill
	localparam logic [4:0] IDX_NULL       = 5'h00;
	localparam logic [4:0] IDX_MSB_LAST   = 5'h0a;
	localparam logic [4:0] IDX_LSB_LAST   = 5'h13;
	localparam logic [4:0] IDX_FILL       = 5'h14;
	localparam logic [4:0] RISES_RESULT   = 5'h0c;
	localparam logic [4:0] RISES_LSB      = 5'h09;
	localparam logic [2:0] FIXED_POS_CH   = 3'h0;
	localparam logic [2:0] FIXED_NEG_CH   = 3'h1;
	// shift clock timing made by the host end
	localparam int         CLK_PERIOD_NS  = 5;
	localparam int         SCLK_PERIOD_NS = 2000;
	localparam logic [7:0] SCLK_HALF_CYC  =
		8'((SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// ---- rtl/adc_link_if.sv ----
// select, shift clock and shared data line between host and converter
`default_nettype none
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic host_do;
	logic host_oe;
	logic dev_do;
	logic dev_oe;
	logic line;
	// resolved data line, pulled high when nobody drives it
	assign line = dev_oe ? dev_do : (host_oe ? host_do : 1'b1);
	modport device (input cs_n, input sclk, input line, output dev_do, output dev_oe);
	modport host (input line, output cs_n, output sclk, output host_do, output host_oe);
endinterface
`default_nettype wire

// ---- rtl/adc_dev_end.sv ----
// converter end: serial sequencer, configuration capture and result shifter
`default_nettype none
module adc_dev_end
	import adc_serial_pkg::*;
#(
	parameter variant_t VARIANT = VAR_EIGHT_CH
) (
	input  wire logic                i_core_clk,
	input  wire logic                i_nrst,
	adc_link_if.device               link,
	input  wire logic [RESULT_W-1:0] i_result,
	output logic                     o_conv_start,
	output logic [2:0]               o_chan_pos,
	output logic [2:0]               o_chan_neg,
	output logic                     o_neg_is_ref,
	output logic                     o_unipolar,
	output logic                     o_busy
);
	localparam logic [2:0] CFG_N = (VARIANT == VAR_TWO_CH) ? CFG_BITS_TWO : CFG_BITS_MULTI;

	dev_state_t          state;
	dev_state_t          next_state;
	logic                sclk_q;
	logic [2:0]          cnt;
	logic [2:0]          next_cnt;
	logic [4:0]          sr;
	logic [4:0]          next_sr;
	logic [4:0]          idx;
	logic [4:0]          next_idx;
	logic [RESULT_W-1:0] res;
	logic [RESULT_W-1:0] next_res;
	logic                order;
	logic                next_order;
	logic                next_do;
	logic                next_oe;
	logic                next_start;
	logic [2:0]          next_pos;
	logic [2:0]          next_neg;
	logic                next_ref;
	logic                next_uni;
	logic                rise;
	logic                fall;
	logic [5:0]          word;
	logic                w_mode;
	logic                w_par;
	logic [1:0]          w_sel;
	logic                w_pol;
	logic                w_order;
	logic [2:0]          base;

	// bit that goes out at a given index; zero fill past the end
	function automatic logic tx_bit(input logic [4:0] i, input logic [RESULT_W-1:0] r,
			input logic ord);
		tx_bit = 1'b0;
		if (i > IDX_NULL && i <= IDX_MSB_LAST) begin
			tx_bit = r[4'(IDX_MSB_LAST - i)];
		end else if (!ord && i > IDX_MSB_LAST && i <= IDX_LSB_LAST) begin
			tx_bit = r[4'(i - IDX_MSB_LAST)];
		end
	endfunction

	// edges of the shift clock, seen one core cycle late on both sides
	assign rise = link.sclk & ~sclk_q;
	assign fall = ~link.sclk & sclk_q;

	// configuration word as received, two-channel word right-aligned in the low three bits
	always_comb begin
		word = {sr, link.line};
		if (VARIANT == VAR_TWO_CH) begin
			w_mode  = word[2];
			w_par   = word[1];
			w_sel   = 2'h0;
			w_pol   = 1'b1;
			w_order = word[0];
		end else begin
			w_mode  = word[POS_MODE];
			w_par   = word[POS_PARITY];
			w_sel   = {word[POS_SEL_HI], word[POS_SEL_LO]};
			w_pol   = word[POS_POLARITY];
			w_order = word[POS_ORDER];
		end
		base = {w_sel, 1'b0};
	end

	// sequencer next values
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_sr    = sr;
		next_idx   = idx;
		next_res   = res;
		next_order = order;
		next_do    = link.dev_do;
		next_oe    = link.dev_oe;
		next_start = 1'b0;
		next_pos   = o_chan_pos;
		next_neg   = o_chan_neg;
		next_ref   = o_neg_is_ref;
		next_uni   = o_unipolar;
		if (link.cs_n) begin
			// select high wins over any clock edge in the same cycle
			next_state = DS_IDLE;
			next_oe    = 1'b0;
			next_do    = 1'b0;
			next_cnt   = 3'h0;
			next_idx   = IDX_NULL;
		end else begin
			case (state)
				DS_IDLE: begin
					next_state = DS_HUNT;
				end
				DS_HUNT: begin
					if (rise && VARIANT == VAR_NO_DIN) begin
						next_state = DS_ARMED;
						next_order = 1'b0;
						next_pos   = FIXED_POS_CH;
						next_neg   = FIXED_NEG_CH;
						next_ref   = 1'b0;
						next_uni   = 1'b1;
						next_start = 1'b1;
					end else if (rise && link.line) begin
						next_state = DS_CFG;
						next_cnt   = 3'h0;
					end
				end
				DS_CFG: begin
					if (rise) begin
						next_sr  = word[4:0];
						next_cnt = cnt + 3'h1;
						if (cnt + 3'h1 == CFG_N) begin
							next_state = DS_ARMED;
							next_pos   = base | {2'h0, w_par};
							next_neg   = w_mode ? 3'h0 : (base | {2'h0, ~w_par});
							next_ref   = w_mode;
							next_uni   = w_pol;
							next_order = w_order;
							next_start = 1'b1;
						end
					end
				end
				DS_ARMED: begin
					if (fall) begin
						next_state = DS_TX;
						next_oe    = 1'b1;
						next_do    = 1'b0;
						next_idx   = IDX_NULL;
					end
				end
				DS_TX: begin
					// data line input is no longer looked at here
					if (fall) begin
						next_idx = (idx == IDX_FILL) ? IDX_FILL : idx + 5'h01;
						if (idx == IDX_NULL) begin
							next_res = i_result;
							next_do  = tx_bit(5'h01, i_result, order);
						end else begin
							next_do  = tx_bit(idx + 5'h01, res, order);
						end
					end
				end
				default: begin
					next_state = DS_IDLE;
				end
			endcase
		end
	end

	// registers of the sequencer
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state        <= DS_IDLE;
			sclk_q       <= 1'b0;
			cnt          <= 3'h0;
			sr           <= 5'h00;
			idx          <= IDX_NULL;
			res          <= 10'h000;
			order        <= 1'b1;
			link.dev_do  <= 1'b0;
			link.dev_oe  <= 1'b0;
			o_conv_start <= 1'b0;
			o_chan_pos   <= FIXED_POS_CH;
			o_chan_neg   <= FIXED_NEG_CH;
			o_neg_is_ref <= 1'b0;
			o_unipolar   <= 1'b1;
			o_busy       <= 1'b0;
		end else begin
			state        <= next_state;
			sclk_q       <= link.sclk;
			cnt          <= next_cnt;
			sr           <= next_sr;
			idx          <= next_idx;
			res          <= next_res;
			order        <= next_order;
			link.dev_do  <= next_do;
			link.dev_oe  <= next_oe;
			o_conv_start <= next_start;
			o_chan_pos   <= next_pos;
			o_chan_neg   <= next_neg;
			o_neg_is_ref <= next_ref;
			o_unipolar   <= next_uni;
			o_busy       <= (next_state != DS_IDLE);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/adc_host_end.sv ----
// controller end: makes select and shift clock, sends word, collects result
`default_nettype none
module adc_host_end
	import adc_serial_pkg::*;
#(
	parameter variant_t VARIANT = VAR_EIGHT_CH
) (
	input  wire logic                i_core_clk,
	input  wire logic                i_nrst,
	adc_link_if.host                 link,
	input  wire logic                i_start,
	input  wire logic                i_mode,
	input  wire logic                i_parity,
	input  wire logic [1:0]          i_sel,
	input  wire logic                i_polarity,
	input  wire logic                i_bit_order,
	output logic                     o_busy,
	output logic                     o_done,
	output logic [RESULT_W-1:0]      o_result,
	output logic                     o_lsb_ok
);
	localparam logic [4:0] N = (VARIANT == VAR_NO_DIN) ? 5'h00 :
		(VARIANT == VAR_TWO_CH) ? {2'h0, CFG_BITS_TWO} : {2'h0, CFG_BITS_MULTI};

	host_state_t   state;
	host_state_t   next_state;
	logic [7:0]    div;
	logic [7:0]    next_div;
	logic [4:0]    rcnt;
	logic [4:0]    next_rcnt;
	logic [4:0]    total;
	logic [4:0]    next_total;
	logic [6:0]    tx;
	logic [6:0]    next_tx;
	logic [9:0]    msb;
	logic [9:0]    next_msb;
	logic [8:0]    lsb;
	logic [8:0]    next_lsb;
	logic          next_cs_n;
	logic          next_sclk;
	logic          next_hdo;
	logic          next_hoe;
	logic          next_done;
	logic [9:0]    next_result;
	logic          next_ok;
	logic          tick;
	logic          ord;
	logic          match;
	logic [4:0]    r;

	assign tick = (div == SCLK_HALF_CYC - 8'h01);
	assign ord  = (VARIANT == VAR_NO_DIN) ? 1'b0 : i_bit_order;

	// lsb-first copy must mirror bits 9..1 of the msb-first copy
	always_comb begin
		match = 1'b1;
		for (int k = 1; k < RESULT_W; k++) begin
			if (msb[k] != lsb[RESULT_W - 1 - k]) begin
				match = 1'b0;
			end
		end
	end

	// exchange sequencer next values
	always_comb begin
		next_state  = state;
		next_div    = tick ? 8'h00 : div + 8'h01;
		next_rcnt   = rcnt;
		next_total  = total;
		next_tx     = tx;
		next_msb    = msb;
		next_lsb    = lsb;
		next_cs_n   = link.cs_n;
		next_sclk   = link.sclk;
		next_hdo    = link.host_do;
		next_hoe    = link.host_oe;
		next_done   = 1'b0;
		next_result = o_result;
		next_ok     = o_lsb_ok;
		r           = rcnt + 5'h01;
		case (state)
			HS_IDLE: begin
				next_div = 8'h00;
				if (i_start) begin
					// start bit first, then fields in transmit order
					next_tx = (VARIANT == VAR_TWO_CH) ? {1'b1, i_mode, i_parity, i_bit_order, 3'h0}
						: {1'b1, i_mode, i_parity, i_sel, i_polarity, i_bit_order};
					next_total = N + RISES_RESULT + (ord ? 5'h00 : RISES_LSB);
					next_cs_n  = 1'b0;
					next_hoe   = (VARIANT != VAR_NO_DIN);
					next_hdo   = 1'b1;
					next_rcnt  = 5'h00;
					next_state = HS_SETUP;
				end
			end
			HS_SETUP: begin
				if (tick) begin
					next_sclk  = 1'b1;
					next_rcnt  = 5'h01;
					next_state = HS_CLK;
				end
			end
			HS_CLK: begin
				if (tick && link.sclk) begin
					next_sclk = 1'b0;
					if (rcnt == total) begin
						next_cs_n   = 1'b1;
						next_hoe    = 1'b0;
						next_done   = 1'b1;
						next_result = msb;
						// order taken from the latched length, not the live pin
						next_ok     = (total == N + RISES_RESULT) | match;
						next_state  = HS_GAP;
					end else begin
						next_tx  = {tx[5:0], 1'b0};
						next_hdo = tx[5];
						if (rcnt == N + 5'h01) begin
							next_hoe = 1'b0;
						end
					end
				end else if (tick) begin
					next_sclk = 1'b1;
					next_rcnt = r;
					if (r >= N + 5'h03 && r <= N + RISES_RESULT) begin
						next_msb = {msb[8:0], link.line};
					end else if (r > N + RISES_RESULT) begin
						next_lsb = {lsb[7:0], link.line};
					end
				end
			end
			HS_GAP: begin
				if (tick) begin
					next_state = HS_IDLE;
				end
			end
			default: begin
				next_state = HS_IDLE;
			end
		endcase
	end

	// registers of the sequencer
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state        <= HS_IDLE;
			div          <= 8'h00;
			rcnt         <= 5'h00;
			total        <= 5'h00;
			tx           <= 7'h00;
			msb          <= 10'h000;
			lsb          <= 9'h000;
			link.cs_n    <= 1'b1;
			link.sclk    <= 1'b0;
			link.host_do <= 1'b0;
			link.host_oe <= 1'b0;
			o_busy       <= 1'b0;
			o_done       <= 1'b0;
			o_result     <= 10'h000;
			o_lsb_ok     <= 1'b0;
		end else begin
			state        <= next_state;
			div          <= next_div;
			rcnt         <= next_rcnt;
			total        <= next_total;
			tx           <= next_tx;
			msb          <= next_msb;
			lsb          <= next_lsb;
			link.cs_n    <= next_cs_n;
			link.sclk    <= next_sclk;
			link.host_do <= next_hdo;
			link.host_oe <= next_hoe;
			o_busy       <= (next_state != HS_IDLE);
			o_done       <= next_done;
			o_result     <= next_result;
			o_lsb_ok     <= next_ok;
		end
	end
endmodule
`default_nettype wire

// ---- verif/adc_link_chk.sv ----
// link checker: order and timing of select, shift clock and data line
`default_nettype none
module adc_link_chk #(
	parameter int CFG_RISES = 7
) (
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic host_do,
	input  wire logic host_oe,
	input  wire logic dev_do,
	input  wire logic dev_oe,
	input  wire logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       sclk_q;
	logic [4:0] rise_cnt;
	logic       next_sclk_q;
	logic [4:0] next_rise_cnt;
	// count shift clock rises inside one select window
	always_comb begin
		next_sclk_q = sclk;
		next_rise_cnt = rise_cnt;
		if (cs_n) begin
			next_rise_cnt = 5'h0;
		end else if (sclk && !sclk_q) begin
			next_rise_cnt = rise_cnt + 5'h1;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sclk_q <= 1'b0;
			rise_cnt <= 5'h0;
		end else begin
			sclk_q <= next_sclk_q;
			rise_cnt <= next_rise_cnt;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// two cycles of slack: the device sees the select rise one cycle late
	a_cs_high_quiet: assert property (
		cs_n && $past(cs_n) && $past(cs_n, 2) |-> !dev_oe) else $error("line driven while idle");
	a_no_contention: assert property (
		!(dev_oe && host_oe)) else $error("both ends drive the line");
	a_dev_shift_fall: assert property (
		dev_oe && $past(dev_oe) && $changed(dev_do) |-> !sclk && ($past(sclk, 2) || $past(sclk, 3)))
		else $error("device bit changed away from a clock fall");
	a_host_shift_fall: assert property (
		host_oe && $past(host_oe) && $changed(host_do) |-> !sclk && $past(sclk))
		else $error("host bit changed away from a clock fall");
	a_line_steady_rise: assert property (
		$rose(sclk) |-> $stable(line)) else $error("line moved at sampling rise");
	a_start_first: assert property (
		$fell(cs_n) |-> host_oe && host_do && !sclk) else $error("start bit not presented");
	a_setup_half: assert property (
		$fell(cs_n) |-> (!sclk) [*8]) else $error("clock rose too soon after select");
	a_word_length: assert property (
		$rose(dev_oe) |-> !cs_n && rise_cnt == 5'(CFG_RISES)) else $error("word length wrong");
	a_null_first: assert property (
		$rose(dev_oe) |-> !dev_do) else $error("null bit not low");
	a_cs_ends: assert property (
		$rose(cs_n) |-> !sclk && !host_oe
		&& (rise_cnt == 5'(CFG_RISES + 11) || rise_cnt == 5'(CFG_RISES + 20)))
		else $error("exchange length wrong");
	a_cs_idle_clock: assert property (
		cs_n |-> !sclk) else $error("clock runs while deselected");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// bench for the converter link: both ends joined, exchanges checked end to end
`default_nettype none
module tb import adc_serial_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic                i_core_clk  = 1'b0;
	logic                i_nrst      = 1'b0;
	logic                i_start     = 1'b0;
	logic                i_mode      = 1'b0;
	logic                i_parity    = 1'b0;
	logic [1:0]          i_sel       = 2'h0;
	logic                i_polarity  = 1'b0;
	logic                i_bit_order = 1'b0;
	logic [RESULT_W-1:0] i_result    = 10'h000;
	logic                o_conv_start, dev_busy, o_neg_is_ref, o_unipolar;
	logic                host_busy, o_done, o_lsb_ok, sclk_q, cs_q;
	logic [2:0]          o_chan_pos, o_chan_neg;
	logic [RESULT_W-1:0] o_result;
	logic [26:0]         seen;
	int                  mismatches  = 0;
	int                  check_count = 0;
	adc_link_if link ();
	adc_dev_end #(.VARIANT(VAR_EIGHT_CH)) u_adc_dev_end (
		.i_core_clk(i_core_clk), .i_nrst(i_nrst), .link(link), .i_result(i_result),
		.o_conv_start(o_conv_start), .o_chan_pos(o_chan_pos), .o_chan_neg(o_chan_neg),
		.o_neg_is_ref(o_neg_is_ref), .o_unipolar(o_unipolar), .o_busy(dev_busy));
	adc_host_end #(.VARIANT(VAR_EIGHT_CH)) u_adc_host_end (
		.i_core_clk(i_core_clk), .i_nrst(i_nrst), .link(link), .i_start(i_start),
		.i_mode(i_mode), .i_parity(i_parity), .i_sel(i_sel), .i_polarity(i_polarity),
		.i_bit_order(i_bit_order), .o_busy(host_busy), .o_done(o_done),
		.o_result(o_result), .o_lsb_ok(o_lsb_ok));
	adc_link_chk #(.CFG_RISES(7)) u_adc_link_chk (
		.i_core_clk(i_core_clk), .i_nrst(i_nrst), .cs_n(link.cs_n), .sclk(link.sclk),
		.host_do(link.host_do), .host_oe(link.host_oe), .dev_do(link.dev_do),
		.dev_oe(link.dev_oe), .line(link.line));
	always #2.5 i_core_clk = ~i_core_clk;
	// wire capture: every bit on the line at a clock rise, cleared at select fall
	always @(posedge i_core_clk) begin
		sclk_q <= link.sclk;
		cs_q <= link.cs_n;
		if (cs_q && !link.cs_n) begin
			seen <= 27'h0;
		end else if (link.sclk && !sclk_q) begin
			seen <= {seen[25:0], link.line};
		end
	end
	task automatic chk(input string what, input logic [26:0] got, input logic [26:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// start is ignored while the host still counts its gap, so wait for idle first
	task automatic launch(input logic [5:0] cfg, input logic [9:0] res);
		@(posedge i_core_clk);
		#1;
		while (host_busy !== 1'b0) begin
			@(posedge i_core_clk);
			#1;
		end
		@(posedge i_core_clk);
		{i_mode, i_parity, i_sel, i_polarity, i_bit_order} <= cfg;
		i_result <= res;
		i_start <= 1'b1;
		@(posedge i_core_clk);
		i_start <= 1'b0;
	endtask
	// one exchange; cfg is mode, parity, select, polarity, order
	task automatic xfer(input logic [5:0] cfg, input logic [9:0] res);
		logic [26:0] exp;
		int          n;
		launch(cfg, res);
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			n++;
		end while (o_conv_start !== 1'b1 && n < 20000);
		// a wait that runs out shows up here as a mismatch
		chk("start", 27'(o_conv_start), 27'h1);
		chk("dev busy", 27'(dev_busy), 27'h1);
		@(posedge i_core_clk);
		#1;
		chk("pos", 27'(o_chan_pos), 27'({cfg[3:2], cfg[4]}));
		chk("neg", 27'(o_chan_neg), cfg[5] ? 27'h0 : 27'({cfg[3:2], ~cfg[4]}));
		chk("ref", 27'(o_neg_is_ref), 27'(cfg[5]));
		chk("uni", 27'(o_unipolar), 27'(cfg[1]));
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			n++;
		end while (o_done !== 1'b1 && n < 20000);
		chk("done", 27'(o_done), 27'h1);
		// msb-first copy always; lsb-first copy only when order bit is low
		exp = {9'h000, 1'b1, cfg, 1'b0, res};
		for (int i = 1; i < 10; i++) begin
			if (!cfg[0]) exp = {exp[25:0], res[i]};
		end
		chk("wire", seen, exp);
		chk("result", 27'(o_result), 27'(res));
		chk("lsb", 27'(o_lsb_ok), 27'h1);
		$display("exchange %h done", cfg);
	endtask
	// watchdog well past the five exchanges below
	initial begin
		repeat (60000) @(posedge i_core_clk);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		xfer(6'h2b, 10'h2a5);
		xfer(6'h1c, 10'h1c3);
		xfer(6'h02, 10'h3ff);
		// reset while the device is sending must release the line
		launch(6'h02, 10'h3ff);
		repeat (3000) @(posedge i_core_clk);
		#1;
		chk("dev_oe live", 27'(link.dev_oe), 27'h1);
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1;
		chk("cs_n", 27'(link.cs_n), 27'h1);
		chk("dev_oe", 27'(link.dev_oe), 27'h0);
		chk("busy", 27'(host_busy), 27'h0);
		chk("dev busy", 27'(dev_busy), 27'h0);
		@(posedge i_core_clk);
		i_nrst <= 1'b1;
		$display("abort done");
		xfer(6'h35, 10'h001);
		close_out();
	end
endmodule
`default_nettype wire
